/* File: rtl/gmc_regs.sv */
// mode, control/status and lookup table registers of the battery gauge
//
// Overview of operation
// - mode bit 0 picks mixed (0) or power-saving voltage mode (1); resets 1.
// - mode bit 1 connects battery-detect pull-up when 1; resets 1.
// - mode bit 2 forces charger-disable output high; 0 lets logic drive it.
// - mode bit 4 low holds standby and freezes counters; high operates.
// - writing mode bit 5 forces counter state, clears relax count; self-clears.
// - writing mode bit 6 forces voltage state, loads relax max; self-clears.
// - reading control bit 0 returns the present alarm pin level.
// - written control bit 0: 0 forces alarm low, 1 lets alarms drive.
// - writing 1 to counter-clear bit resets conversion counter; self-clears.
// - read-only control bit 2 shows SOC source, 1 voltage mode; resets 0.
// - bit 3 sets on battery removal; write 0 clears only while detect low.
// - control bit 4 reads 1 after a power-on reset event.
// - writing bit 4 sets/clears soft reset and power-on flag; self-clears.
// - bits 5..7 sticky low-SOC, low-voltage, undervoltage flags; write 0 clears.
// - sixteen SOC bytes and sixteen OCV words loaded with defaults at reset.
// - every register returns to its default at power-on; soft reset reloads only mode, control and table registers.
// - OCV words keep low byte at lower address, high byte next.
`timescale 1ns/1ps

module gmc_regs (
  // clock, reset, enable
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_ce,
  // byte register port from the serial bus engine
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  output logic      [7:0]  o_rdata,
  // device pins
  input  wire logic        i_battery_detect_input,
  input  wire logic        i_alarm_pin,
  output logic             o_alarm_pin_o,
  output logic             o_alarm_pin_oe,
  output logic             o_charger_disable_output,
  output logic             o_detect_pullup_enable,
  // gauge core events and state
  input  wire logic        i_charger_disable_logic,
  input  wire logic        i_alarm_condition,
  input  wire logic        i_soc_source_voltage,
  input  wire logic        i_low_charge_event,
  input  wire logic        i_low_voltage_event,
  input  wire logic        i_undervoltage_event,
  // controls to gauge core
  output logic             o_power_saving_select,
  output logic             o_alarm_function_enable,
  output logic             o_gauge_operate,
  output logic             o_force_counter_state,
  output logic             o_force_voltage_state,
  output logic             o_conversion_count_clear,
  output logic             o_soft_reset,
  output logic             o_relax_state
);

  logic [6:0]  mode_reg;
  logic        alarm_drive_reg;
  logic        soc_source_reg;
  logic        bat_rem_reg;
  logic        por_reg;
  logic [2:0]  alarm_flags_reg;
  logic        force_counter_state_reg;
  logic        force_voltage_state_reg;
  logic        cnt_clear_reg;
  logic        soft_reset_reg;
  logic [7:0]  rdata_reg;
  logic [7:0]  soc_tab_reg [16];
  logic [15:0] ocv_tab_reg [16];
  logic [1:0]  det_sync_reg;
  logic [1:0]  alarm_sync_reg;
  gmc_pkg::gmc_relax_e relax_reg;

  function automatic logic in_range(input logic [7:0] a,
                                    input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  wire logic       wr_en      = i_ce & i_wr;
  wire logic       wr_mode    = wr_en & (i_addr == gmc_pkg::ADDR_MODE);
  wire logic       wr_ctrl    = wr_en & (i_addr == gmc_pkg::ADDR_CTRL);
  wire logic       hit_ocv    = in_range(i_addr, gmc_pkg::ADDR_OCV_BASE,
                                         gmc_pkg::ADDR_OCV_LAST);
  wire logic       hit_soc    = in_range(i_addr, gmc_pkg::ADDR_SOC_BASE,
                                         gmc_pkg::ADDR_SOC_LAST);
  wire logic [7:0] ocv_off    = i_addr - gmc_pkg::ADDR_OCV_BASE;
  wire logic [7:0] soc_off    = i_addr - gmc_pkg::ADDR_SOC_BASE;
  wire logic [3:0] ocv_idx    = ocv_off[4:1];
  wire logic       ocv_hi     = ocv_off[0];
  wire logic [3:0] soc_idx    = soc_off[3:0];
  wire logic       det_level  = det_sync_reg[1];
  wire logic       alarm_level = alarm_sync_reg[1];
  // soft reset reloads mode, control and table defaults; the relaxation state is kept
  wire logic       soft_rst   = i_ce & soft_reset_reg;

  // clear-on-write-0 helper; a hardware set in the same cycle wins
  wire logic [7:0] wctl       = i_wdata;
  wire logic [2:0] flag_clear = {3{wr_ctrl}} &
                                ~wctl[gmc_pkg::CTRL_UVLO:gmc_pkg::CTRL_LOW_SOC];
  wire logic [2:0] flag_set   = {i_undervoltage_event, i_low_voltage_event,
                                 i_low_charge_event};
  wire logic       bat_clear  = wr_ctrl & ~wctl[gmc_pkg::CTRL_BAT_REM] &
                                ~det_level;

  // read multiplexer
  logic [7:0] ctrl_view;
  logic [7:0] rd_mux;
  always_comb begin
    ctrl_view = 8'h00;
    ctrl_view[gmc_pkg::CTRL_ALARM_IO]  = alarm_level;
    ctrl_view[gmc_pkg::CTRL_SOC_SRC]   = soc_source_reg;
    ctrl_view[gmc_pkg::CTRL_BAT_REM]   = bat_rem_reg;
    ctrl_view[gmc_pkg::CTRL_POR]       = por_reg;
    ctrl_view[gmc_pkg::CTRL_UVLO:gmc_pkg::CTRL_LOW_SOC] = alarm_flags_reg;
    rd_mux = 8'h00;
    if (i_addr == gmc_pkg::ADDR_MODE) begin
      // bit 7 reads zero; force bits always read zero
      rd_mux = {1'b0, 2'b00, mode_reg[4:0]};
    end else if (i_addr == gmc_pkg::ADDR_CTRL) begin
      rd_mux = ctrl_view;
    end else if (hit_ocv) begin
      rd_mux = ocv_hi ? ocv_tab_reg[ocv_idx][15:8]
                      : ocv_tab_reg[ocv_idx][7:0];
    end else if (hit_soc) begin
      rd_mux = soc_tab_reg[soc_idx];
    end
  end

  // pin synchronisers
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      det_sync_reg <= 2'b00;
      alarm_sync_reg <= 2'b00;
    end else if (i_ce) begin
      det_sync_reg <= {det_sync_reg[0], i_battery_detect_input};
      alarm_sync_reg <= {alarm_sync_reg[0], i_alarm_pin};
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode_reg        <= gmc_pkg::MODE_RESET[6:0];
      alarm_drive_reg <= gmc_pkg::ALARM_IO_RESET;
      bat_rem_reg     <= 1'b0;
      alarm_flags_reg <= 3'b000;
      soc_source_reg  <= 1'b0;
    end else if (soft_rst) begin
      mode_reg        <= gmc_pkg::MODE_RESET[6:0];
      alarm_drive_reg <= gmc_pkg::ALARM_IO_RESET;
      bat_rem_reg     <= 1'b0;
      alarm_flags_reg <= 3'b000;
      soc_source_reg  <= 1'b0;
    end else if (i_ce) begin
      if (wr_mode) begin
        mode_reg[4:0] <= i_wdata[4:0];
      end
      if (wr_ctrl) begin
        alarm_drive_reg <= wctl[gmc_pkg::CTRL_ALARM_IO];
      end
      soc_source_reg  <= i_soc_source_voltage;
      bat_rem_reg     <= det_level | (bat_rem_reg & ~bat_clear);
      alarm_flags_reg <= flag_set | (alarm_flags_reg & ~flag_clear);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      force_counter_state_reg   <= 1'b0;
      force_voltage_state_reg   <= 1'b0;
      cnt_clear_reg  <= 1'b0;
      soft_reset_reg <= 1'b0;
      por_reg        <= gmc_pkg::POR_RESET;
    end else if (i_ce) begin
      force_counter_state_reg   <= wr_mode & i_wdata[gmc_pkg::MODE_FORCE_COUNTER_STATE];
      force_voltage_state_reg   <= wr_mode & i_wdata[gmc_pkg::MODE_FORCE_VOLTAGE_STATE];
      cnt_clear_reg  <= wr_ctrl & wctl[gmc_pkg::CTRL_CNT_CLEAR];
      soft_reset_reg <= wr_ctrl & wctl[gmc_pkg::CTRL_POR];
      if (wr_ctrl) begin
        // write sets or clears power-on flag
        por_reg <= wctl[gmc_pkg::CTRL_POR];
      end
    end
  end

  // relaxation state; has priority if both forced together
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      relax_reg <= gmc_pkg::GMC_RELAX_CC;
    end else if (i_ce) begin
      if (wr_mode && i_wdata[gmc_pkg::MODE_FORCE_COUNTER_STATE]) begin
        relax_reg <= gmc_pkg::GMC_RELAX_CC;
      end else if (wr_mode && i_wdata[gmc_pkg::MODE_FORCE_VOLTAGE_STATE]) begin
        relax_reg <= gmc_pkg::GMC_RELAX_VM;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      soc_tab_reg <= gmc_pkg::SOC_DEFAULT;
      ocv_tab_reg <= gmc_pkg::OCV_DEFAULT;
    end else if (soft_rst) begin
      soc_tab_reg <= gmc_pkg::SOC_DEFAULT;
      ocv_tab_reg <= gmc_pkg::OCV_DEFAULT;
    end else if (wr_en) begin
      if (hit_soc) begin
        soc_tab_reg[soc_idx] <= i_wdata;
      end
      if (hit_ocv && ocv_hi) begin
        ocv_tab_reg[ocv_idx][15:8] <= i_wdata;
      end
      if (hit_ocv && !ocv_hi) begin
        ocv_tab_reg[ocv_idx][7:0] <= i_wdata;
      end
    end
  end

  // read data registered on a read strobe
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_reg <= 8'h00;
    end else if (i_ce && i_rd) begin
      rdata_reg <= rd_mux;
    end
  end

  // alarm pin is open-drain: it only ever pulls low
  wire logic alarm_low = ~alarm_drive_reg |
                         (mode_reg[gmc_pkg::MODE_ALARM_EN] & i_alarm_condition);

  assign o_rdata                  = rdata_reg;
  assign o_alarm_pin_o            = 1'b0;
  assign o_alarm_pin_oe           = alarm_low;
  assign o_charger_disable_output = mode_reg[gmc_pkg::MODE_CHG_FORCE] |
                                    i_charger_disable_logic;
  assign o_detect_pullup_enable   = mode_reg[gmc_pkg::MODE_PULLUP];
  assign o_power_saving_select    = mode_reg[gmc_pkg::MODE_POWER_SAVE];
  assign o_alarm_function_enable  = mode_reg[gmc_pkg::MODE_ALARM_EN];
  assign o_gauge_operate          = mode_reg[gmc_pkg::MODE_OPERATE];
  assign o_force_counter_state    = force_counter_state_reg;
  assign o_force_voltage_state    = force_voltage_state_reg;
  assign o_conversion_count_clear = cnt_clear_reg;
  assign o_soft_reset             = soft_reset_reg;
  assign o_relax_state            = relax_reg;

endmodule : gmc_regs

/* File: pkg/gmc_pkg.sv */
// shared constants for the gauge mode and control register bank
package gmc_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_MODE     = 8'h00;
  localparam logic [7:0] ADDR_CTRL     = 8'h01;
  localparam logic [7:0] ADDR_OCV_BASE = 8'h30;
  localparam logic [7:0] ADDR_OCV_LAST = 8'h4f;
  localparam logic [7:0] ADDR_SOC_BASE = 8'h50;
  localparam logic [7:0] ADDR_SOC_LAST = 8'h5f;

  // mode register bit positions
  localparam int MODE_POWER_SAVE = 0;
  localparam int MODE_PULLUP     = 1;
  localparam int MODE_CHG_FORCE  = 2;
  localparam int MODE_ALARM_EN   = 3;
  localparam int MODE_OPERATE    = 4;
  localparam int MODE_FORCE_COUNTER_STATE   = 5;
  localparam int MODE_FORCE_VOLTAGE_STATE   = 6;

  // control register bit positions
  localparam int CTRL_ALARM_IO   = 0;
  localparam int CTRL_CNT_CLEAR  = 1;
  localparam int CTRL_SOC_SRC    = 2;
  localparam int CTRL_BAT_REM    = 3;
  localparam int CTRL_POR        = 4;
  localparam int CTRL_LOW_SOC    = 5;
  localparam int CTRL_LOW_VOLT   = 6;
  localparam int CTRL_UVLO       = 7;

  // values after reset
  localparam logic [7:0] MODE_RESET     = 8'h0b;
  localparam logic       ALARM_IO_RESET = 1'b1;
  localparam logic       POR_RESET      = 1'b1;

  // default table contents
  localparam logic [7:0] SOC_DEFAULT [16] = '{
    8'h00, 8'h06, 8'h0c, 8'h14, 8'h1e, 8'h28, 8'h32, 8'h3c,
    8'h50, 8'h64, 8'h78, 8'h82, 8'h8c, 8'ha0, 8'hb4, 8'hc8};
  localparam logic [15:0] OCV_DEFAULT [16] = '{
    16'h1770, 16'h1926, 16'h19b2, 16'h19fb,
    16'h1a3e, 16'h1a6d, 16'h1a9d, 16'h1ab6,
    16'h1ad5, 16'h1b01, 16'h1b70, 16'h1bb1,
    16'h1be8, 16'h1c58, 16'h1cf3, 16'h1da9};

  // relaxation state encoding
  typedef enum logic [0:0] {
    GMC_RELAX_CC = 1'b0,
    GMC_RELAX_VM = 1'b1
  } gmc_relax_e;

endpackage : gmc_pkg

/* File: bench/gmc_host.sv */
// host side model issuing byte accesses on the register port
`timescale 1ns/1ps

module gmc_host (
  // clock
  input  wire logic       i_clk,
  // byte access strobes towards the register bank
  output logic            o_wr,
  output logic            o_rd,
  output logic [7:0]      o_addr,
  output logic [7:0]      o_wdata
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end

  // one access, launched just after an edge and taken at the next
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(posedge i_clk);
    #1;
    o_wr = w;
    o_rd = !w;
    o_addr = a;
    o_wdata = d;
    @(posedge i_clk);
    #1;
    o_wr = 1'b0;
    o_rd = 1'b0;
    // released lines must not keep looking valid
    o_addr = ~a;
    o_wdata = ~d;
  endtask : acc
endmodule : gmc_host

/* File: bench/gmc_regs_assertions.sv */
// concurrent checks on the gauge register bank ports
`timescale 1ns/1ps

module gmc_regs_assertions (
  input wire logic       i_clk,
  input wire logic       i_rst_b,
  input wire logic       i_ce,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic       o_alarm_pin_o,
  input wire logic       o_alarm_pin_oe,
  input wire logic       o_charger_disable_output,
  input wire logic       o_detect_pullup_enable,
  input wire logic       o_gauge_operate,
  input wire logic       o_force_counter_state,
  input wire logic       o_force_voltage_state,
  input wire logic       o_conversion_count_clear,
  input wire logic       o_soft_reset,
  input wire logic       o_relax_state
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  wire mode_wr = i_ce && i_wr && i_addr == gmc_pkg::ADDR_MODE;
  wire ctrl_wr = i_ce && i_wr && i_addr == gmc_pkg::ADDR_CTRL;

  force_counter_state_a: assert property (
    mode_wr && i_wdata[5] |=> o_force_counter_state && !o_relax_state)
    else $error("force counter pulse wrong");
  force_voltage_state_a: assert property (
    mode_wr && i_wdata[6] && !i_wdata[5]
    |=> o_force_voltage_state && o_relax_state)
    else $error("force voltage pulse wrong");
  count_clear_a: assert property (
    ctrl_wr && i_wdata[1]
    |=> o_conversion_count_clear ##1 !o_conversion_count_clear)
    else $error("count clear pulse wrong");
  // a soft reset reload in flight would mask the written value
  mode_bits_a: assert property (
    mode_wr && !o_soft_reset
    |=> o_detect_pullup_enable == $past(i_wdata[1])
    && o_gauge_operate == $past(i_wdata[4]))
    else $error("mode bits not written");
  chg_force_a: assert property (
    mode_wr && i_wdata[2] && !o_soft_reset
    |=> o_charger_disable_output)
    else $error("charger disable not forced");
  alarm_low_a: assert property (
    ctrl_wr && !i_wdata[0] && !i_wdata[4] && !o_soft_reset
    |=> o_alarm_pin_oe && !o_alarm_pin_o)
    else $error("alarm pin not pulled low");
  soft_reset_a: assert property (
    ctrl_wr && i_wdata[4] |=> o_soft_reset ##1
    (!o_soft_reset && o_detect_pullup_enable && !o_gauge_operate))
    else $error("soft reset sequence wrong");
  mode_high_a: assert property (
    i_ce && i_rd && i_addr == gmc_pkg::ADDR_MODE
    |=> o_rdata[7:5] == 3'h0)
    else $error("mode upper bits not zero");

  cover property (o_soft_reset);
  cover property (o_force_voltage_state);
  cover property (o_alarm_pin_oe);
endmodule : gmc_regs_assertions

bind gmc_regs gmc_regs_assertions i_gmc_regs_assertions (
  .i_clk, .i_rst_b, .i_ce, .i_wr, .i_rd, .i_addr, .i_wdata,
  .o_rdata, .o_alarm_pin_o, .o_alarm_pin_oe,
  .o_charger_disable_output, .o_detect_pullup_enable,
  .o_gauge_operate, .o_force_counter_state, .o_force_voltage_state,
  .o_conversion_count_clear, .o_soft_reset, .o_relax_state);

/* File: bench/tb_gauge_mode_control_regs.sv */
// self-checking bench for the gauge mode and control registers
`timescale 1ns/1ps

module tb_gauge_mode_control_regs;
  logic        i_clk = 1'b0;
  logic        i_rst_b = 1'b0;
  logic        i_ce = 1'b1;
  logic        i_wr, i_rd, apin, aoe, aout, chg_dis, pu;
  logic [7:0]  i_addr, i_wdata, o_rdata;
  logic        det = 1'b0, chg = 1'b0, acnd = 1'b0, src = 1'b0;
  logic        ev = 1'b0, rd_d = 1'b0;
  logic [31:0] rng = 32'hbcf2;
  logic [7:0]  q[$];
  int          err_count = 0, cmp_count = 0;

  always #20 i_clk = ~i_clk;
  // open-drain alarm wire with its pull-up
  assign apin = aoe ? aout : 1'b1;

  gmc_host i_gmc_host (.i_clk, .o_wr(i_wr), .o_rd(i_rd),
    .o_addr(i_addr), .o_wdata(i_wdata));
  gmc_regs i_gmc_regs (.i_clk, .i_rst_b, .i_ce, .i_wr, .i_rd,
    .i_addr, .i_wdata, .o_rdata, .i_battery_detect_input(det),
    .i_alarm_pin(apin), .o_alarm_pin_o(aout), .o_alarm_pin_oe(aoe),
    .o_charger_disable_output(chg_dis), .o_detect_pullup_enable(pu),
    .i_charger_disable_logic(chg), .i_alarm_condition(acnd),
    .i_soc_source_voltage(src), .i_low_charge_event(ev),
    .i_low_voltage_event(ev), .i_undervoltage_event(ev),
    .o_power_saving_select(), .o_alarm_function_enable(),
    .o_gauge_operate(), .o_force_counter_state(),
    .o_force_voltage_state(), .o_conversion_count_clear(),
    .o_soft_reset(), .o_relax_state());

  task automatic check(input string nm, input logic [7:0] s, e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  // read data lands one cycle after the taken read
  always @(posedge i_clk) rd_d <= i_ce & i_rd;
  always @(negedge i_clk) if (rd_d) check("rdata", o_rdata, q.pop_front());

  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : rnd

  task automatic wr_b(input logic [7:0] a, d);
    i_gmc_host.acc(1'b1, a, d);
  endtask : wr_b

  task automatic rd_b(input logic [7:0] a, e);
    q.push_back(e);
    i_gmc_host.acc(1'b0, a, 8'h00);
  endtask : rd_b

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : cyc

  initial begin
    #(40 * 3000);
    err_count++;
    close_out();
  end

  initial begin
    logic [31:0] d;
    int n;
    cyc(16);
    i_rst_b = 1'b1;
    rd_b(8'h00, gmc_pkg::MODE_RESET);
    rd_b(8'h01, 8'h11);
    for (n = 0; n < 16; n++) begin
      rd_b(8'h50 + 8'(n), gmc_pkg::SOC_DEFAULT[n]);
      rd_b(8'h30 + 8'(2 * n), gmc_pkg::OCV_DEFAULT[n][7:0]);
      rd_b(8'h31 + 8'(2 * n), gmc_pkg::OCV_DEFAULT[n][15:8]);
    end
    d = rnd();
    n = int'(d[27:24]);
    wr_b(8'h50 + 8'(n), d[7:0]);
    wr_b(8'h30 + 8'(2 * n), d[15:8]);
    wr_b(8'h31 + 8'(2 * n), d[23:16]);
    rd_b(8'h31 + 8'(2 * n), d[23:16]);
    rd_b(8'h50 + 8'(n), d[7:0]);
    $display("table test done");
    chg = d[28];
    wr_b(8'h00, 8'hff);
    check("chg_dis", {7'h0, chg_dis}, 8'h01);
    rd_b(8'h00, 8'h1f);
    wr_b(8'h00, 8'h40);
    rd_b(8'h00, 8'h00);
    check("chg_dis", {7'h0, chg_dis}, {7'h0, chg});
    check("pullup", {7'h0, pu}, 8'h00);
    wr_b(8'h20, 8'ha5);
    rd_b(8'h20, 8'h00);
    $display("mode test done");
    ev = 1'b1;
    cyc(1);
    ev = 1'b0;
    cyc(3);
    rd_b(8'h01, 8'hf1);
    wr_b(8'h01, 8'h03);
    rd_b(8'h01, 8'h01);
    det = 1'b1;
    src = 1'b1;
    cyc(4);
    wr_b(8'h01, 8'h01);
    rd_b(8'h01, 8'h0d);
    det = 1'b0;
    cyc(4);
    rd_b(8'h01, 8'h0d);
    wr_b(8'h01, 8'h01);
    rd_b(8'h01, 8'h05);
    src = 1'b0;
    $display("flag test done");
    wr_b(8'h01, 8'h00);
    check("oe", {7'h0, aoe}, 8'h01);
    cyc(4);
    rd_b(8'h01, 8'h00);
    wr_b(8'h01, 8'h01);
    cyc(4);
    rd_b(8'h01, 8'h01);
    acnd = 1'b1;
    wr_b(8'h00, 8'h08);
    cyc(4);
    rd_b(8'h01, 8'h00);
    acnd = 1'b0;
    cyc(4);
    $display("alarm test done");
    wr_b(8'h00, 8'h10);
    wr_b(8'h01, 8'h10);
    cyc(2);
    rd_b(8'h00, gmc_pkg::MODE_RESET);
    rd_b(8'h01, 8'h11);
    i_ce = 1'b0;
    wr_b(8'h00, 8'h10);
    i_ce = 1'b1;
    rd_b(8'h00, gmc_pkg::MODE_RESET);
    wr_b(8'h50, 8'h77);
    i_rst_b = 1'b0;
    cyc(2);
    i_rst_b = 1'b1;
    rd_b(8'h50, 8'h00);
    cyc(4);
    check("queue", 8'(q.size()), 8'h00);
    $display("reset test done");
    close_out();
  end
endmodule : tb_gauge_mode_control_regs
